/* File: verilog/rtc_cal_pkg.sv */
// Constants for the calendar and alarm core of the real-time clock
package rtc_cal_pkg;
  localparam int unsigned AUX_HZ = 32768;
  localparam int unsigned PS0_DIV = 256;
  localparam int unsigned PS1_DIV = 128;
  localparam logic [7:0] PS_ZERO = 8'h00;
  localparam logic [7:0] PS0_LAST = 8'(PS0_DIV - 1);
  localparam logic [6:0] PS1_LAST = 7'(PS1_DIV - 1);
  // Keepout: 192 aux ticks before the update and 64 after it
  localparam logic [6:0] KEEP_LO = 7'h7f;
  localparam logic [6:0] KEEP_HI = 7'h00;
  localparam logic [7:0] KEEP_PS0 = 8'h40;
  localparam logic [7:0] SEC_MAX = 8'd59;
  localparam logic [7:0] HOUR_MAX = 8'd23;
  localparam logic [2:0] DOW_MAX = 3'd6;
  localparam logic [7:0] MON_MAX = 8'd12;
  localparam logic [7:0] ONE = 8'd1;
  localparam logic [11:0] YEAR_MAX = 12'd4095;
  localparam logic [3:0] FEB = 4'd2;
  localparam logic [3:0] APR = 4'd4;
  localparam logic [3:0] JUN = 4'd6;
  localparam logic [3:0] SEP = 4'd9;
  localparam logic [3:0] NOV = 4'd11;
  localparam logic [7:0] DAYS_31 = 8'd31;
  localparam logic [7:0] DAYS_30 = 8'd30;
  localparam logic [7:0] DAYS_29 = 8'd29;
  localparam logic [7:0] DAYS_28 = 8'd28;
endpackage : rtc_cal_pkg

/* File: verilog/rtc_calendar_alarm_core.sv */
// Calendar counters, one-second prescalers, alarm and ready logic
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic aux_clk_i,
  input wire logic calendar_select_i,
  input wire logic bcd_format_select_i,
  input wire logic main_count_hold_i,
  input wire logic first_prescaler_hold_i,
  input wire logic second_prescaler_hold_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_sel_i,
  input wire logic [11:0] wr_data_i,
  input wire logic [7:0] alarm_minute_i,
  input wire logic [7:0] alarm_hour_i,
  input wire logic [2:0] alarm_weekday_i,
  input wire logic [7:0] alarm_month_day_i,
  input wire logic [3:0] alarm_field_enable_i,
  input wire logic alarm_flag_clear_i,
  input wire logic time_ready_irq_enable_i,
  input wire logic time_ready_flag_clear_i,
  input wire logic time_ready_serviced_i,
  output logic [7:0] seconds_count_o,
  output logic [7:0] minutes_count_o,
  output logic [7:0] hours_count_o,
  output logic [2:0] weekday_count_o,
  output logic [7:0] month_day_count_o,
  output logic [7:0] month_count_o,
  output logic [7:0] year_low_count_o,
  output logic [7:0] year_high_count_o,
  output logic [7:0] first_prescaler_o,
  output logic [6:0] second_prescaler_o,
  output logic alarm_flag_o,
  output logic time_ready_o,
  output logic time_ready_irq_flag_o,
  output logic time_ready_irq_o
);
  // ************************************************
  // Aux clock synchroniser and edge detect
  // ************************************************
  logic aux_s1_reg, aux_s2_reg, aux_s3_reg, aux_lvl_reg;
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aux_s1_reg <= 1'b0;
      aux_s2_reg <= 1'b0;
      aux_s3_reg <= 1'b0;
      aux_lvl_reg <= 1'b0;
    end
    else
    begin
      aux_s1_reg <= aux_clk_i;
      aux_s2_reg <= aux_s1_reg;
      aux_s3_reg <= aux_s2_reg;
      if (aux_s2_reg == aux_s3_reg)
        aux_lvl_reg <= aux_s3_reg;
    end
  end
  wire logic aux_rise = (aux_s2_reg == aux_s3_reg) && aux_s3_reg && !aux_lvl_reg;

  // ************************************************
  // Mode and format change detection
  // ************************************************
  logic cal_q_reg, bcd_q_reg;
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_q_reg <= 1'b0;
      bcd_q_reg <= 1'b0;
    end
    else
    begin
      cal_q_reg <= calendar_select_i;
      bcd_q_reg <= bcd_format_select_i;
    end
  end
  wire logic enter_cal = calendar_select_i && !cal_q_reg;
  wire logic fmt_chg = bcd_format_select_i != bcd_q_reg;
  wire logic clear_all = enter_cal || fmt_chg;
  // Write stops the count and resets prescalers
  wire logic cal_write = calendar_select_i && wr_en_i;

  // ************************************************
  // Prescalers: divide 256 then 128
  // ************************************************
  // Individual prescaler holds are ignored in calendar mode
  wire logic run = calendar_select_i && !main_count_hold_i && aux_rise;
  logic [7:0] ps0_reg;
  logic [6:0] ps1_reg;
  // First stage wraps on its last count while running
  wire logic ps0_wrap = run && (ps0_reg == rtc_cal_pkg::PS0_LAST);
  wire logic tick = ps0_wrap && (ps1_reg == rtc_cal_pkg::PS1_LAST);
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ps0_reg <= rtc_cal_pkg::PS_ZERO;
      ps1_reg <= 7'h00;
    end
    else if (clear_all || cal_write)
    begin
      ps0_reg <= rtc_cal_pkg::PS_ZERO;
      ps1_reg <= 7'h00;
    end
    else if (run)
    begin
      ps0_reg <= ps0_reg + 8'h01;
      if (ps0_wrap)
        ps1_reg <= ps1_reg + 7'h01;
    end
  end

  // ************************************************
  // Counting helpers for BCD and binary
  // ************************************************
  function automatic logic [7:0] inc(input logic [7:0] v, input logic bcd);
    if (bcd && v[3:0] == 4'h9)
      inc = {v[7:4] + 4'h1, 4'h0};
    else
      inc = v + 8'h01;
  endfunction : inc
  function automatic logic [7:0] bin(input logic [7:0] v, input logic bcd);
    // Widen the tens digit first so the product cannot overflow four bits
    bin = bcd ? ((8'(v[7:4]) * 8'h0a) + 8'(v[3:0])) : v;
  endfunction : bin

  // ************************************************
  // Calendar counters
  // ************************************************
  logic [7:0] sec_reg, min_reg, hour_reg, mday_reg, mon_reg;
  logic [2:0] dow_reg;
  logic [15:0] year_reg;
  wire logic bcd = bcd_format_select_i;
  wire logic [7:0] sec_b = bin(sec_reg, bcd);
  wire logic [7:0] min_b = bin(min_reg, bcd);
  wire logic [7:0] hour_b = bin(hour_reg, bcd);
  wire logic [7:0] mday_b = bin(mday_reg, bcd);
  wire logic [3:0] mon_b = 4'(bin(mon_reg, bcd));
  wire logic [1:0] year_lo2 = bcd ? 2'(year_reg[3:0] + {year_reg[4], 1'b0}) : year_reg[1:0];
  wire logic leap = (year_lo2 == 2'b00);
  wire logic [7:0] mlen = (mon_b == rtc_cal_pkg::FEB) ?
    (leap ? rtc_cal_pkg::DAYS_29 : rtc_cal_pkg::DAYS_28) :
    ((mon_b == rtc_cal_pkg::APR) || (mon_b == rtc_cal_pkg::JUN) ||
     (mon_b == rtc_cal_pkg::SEP) || (mon_b == rtc_cal_pkg::NOV)) ?
    rtc_cal_pkg::DAYS_30 : rtc_cal_pkg::DAYS_31;
  wire logic c_sec = sec_b == rtc_cal_pkg::SEC_MAX;
  wire logic c_min = c_sec && (min_b == rtc_cal_pkg::SEC_MAX);
  wire logic c_hour = c_min && (hour_b == rtc_cal_pkg::HOUR_MAX);
  wire logic c_day = c_hour && (mday_b == mlen);
  wire logic c_mon = c_day && ({4'h0, mon_b} == rtc_cal_pkg::MON_MAX);
  // Binary year counts straight through all 16 bits
  wire logic [15:0] year_inc = year_reg + 16'h0001;
  wire logic [15:0] year_bcd_next = (year_reg[7:0] == 8'h99) ?
    {inc(year_reg[15:8], 1'b1), 8'h00} : {year_reg[15:8], inc(year_reg[7:0], 1'b1)};
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sec_reg <= 8'h00;
      min_reg <= 8'h00;
      hour_reg <= 8'h00;
      dow_reg <= 3'h0;
      mday_reg <= rtc_cal_pkg::ONE;
      mon_reg <= rtc_cal_pkg::ONE;
      year_reg <= 16'h0000;
    end
    else if (clear_all)
    begin
      sec_reg <= 8'h00;
      min_reg <= 8'h00;
      hour_reg <= 8'h00;
      dow_reg <= 3'h0;
      mday_reg <= rtc_cal_pkg::ONE;
      mon_reg <= rtc_cal_pkg::ONE;
      year_reg <= 16'h0000;
    end
    else if (cal_write)
    begin
      unique case (wr_sel_i)
        3'h0: sec_reg <= wr_data_i[7:0];
        3'h1: min_reg <= wr_data_i[7:0];
        3'h2: hour_reg <= wr_data_i[7:0];
        3'h3: dow_reg <= wr_data_i[2:0];
        3'h4: mday_reg <= wr_data_i[7:0];
        3'h5: mon_reg <= wr_data_i[7:0];
        3'h6: year_reg[7:0] <= wr_data_i[7:0];
        3'h7: year_reg[15:8] <= wr_data_i[11:4];
      endcase
    end
    else if (tick)
    begin
      sec_reg <= c_sec ? 8'h00 : inc(sec_reg, bcd);
      if (c_sec)
        min_reg <= c_min ? 8'h00 : inc(min_reg, bcd);
      if (c_min)
      begin
        hour_reg <= c_hour ? 8'h00 : inc(hour_reg, bcd);
      end
      if (c_hour)
      begin
        dow_reg <= (dow_reg == rtc_cal_pkg::DOW_MAX) ? 3'h0 : dow_reg + 3'h1;
        mday_reg <= c_day ? rtc_cal_pkg::ONE : inc(mday_reg, bcd);
      end
      if (c_day)
        mon_reg <= c_mon ? rtc_cal_pkg::ONE : inc(mon_reg, bcd);
      if (c_mon)
        year_reg <= bcd ? year_bcd_next : year_inc;
    end
  end

  // ************************************************
  // Alarm compare
  // ************************************************
  // Next time values at the tick decide a fresh match
  wire logic [7:0] min_next = c_min ? 8'h00 : (c_sec ? inc(min_reg, bcd) : min_reg);
  wire logic [7:0] hour_next = c_hour ? 8'h00 : (c_min ? inc(hour_reg, bcd) : hour_reg);
  wire logic [2:0] dow_next = c_hour ?
    ((dow_reg == rtc_cal_pkg::DOW_MAX) ? 3'h0 : dow_reg + 3'h1) : dow_reg;
  wire logic [7:0] mday_next = c_day ? rtc_cal_pkg::ONE :
    (c_hour ? inc(mday_reg, bcd) : mday_reg);
  wire logic m_min = !alarm_field_enable_i[0] || (min_next == alarm_minute_i);
  wire logic m_hour = !alarm_field_enable_i[1] || (hour_next == alarm_hour_i);
  wire logic m_dow = !alarm_field_enable_i[2] || (dow_next == alarm_weekday_i);
  wire logic m_day = !alarm_field_enable_i[3] || (mday_next == alarm_month_day_i);
  wire logic any_en = |alarm_field_enable_i;
  // Only at the minute rollover, so seconds are zero and it fires once
  wire logic alarm_hit = tick && c_sec && any_en && m_min && m_hour && m_dow && m_day;
  logic alarm_flag_reg;
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      alarm_flag_reg <= 1'b0;
    else if (!calendar_select_i)
      alarm_flag_reg <= 1'b0;
    else if (alarm_hit)
      alarm_flag_reg <= 1'b1;
    else if (alarm_flag_clear_i)
      alarm_flag_reg <= 1'b0;
  end

  // ************************************************
  // Ready bit and ready flag
  // ************************************************
  wire logic keepout = ((ps1_reg == rtc_cal_pkg::KEEP_LO) && (ps0_reg >= rtc_cal_pkg::KEEP_PS0)) ||
    ((ps1_reg == rtc_cal_pkg::KEEP_HI) && (ps0_reg < rtc_cal_pkg::KEEP_PS0));
  wire logic ready_next = calendar_select_i && !keepout;
  logic ready_reg, rflag_reg, rirq_reg;
  wire logic rflag_next = !calendar_select_i ? 1'b0 :
    (ready_next && !ready_reg) ? 1'b1 :
    (time_ready_flag_clear_i || time_ready_serviced_i) ? 1'b0 : rflag_reg;
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_reg <= 1'b0;
      rflag_reg <= 1'b0;
      rirq_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= ready_next;
      rflag_reg <= rflag_next;
      rirq_reg <= rflag_next && time_ready_irq_enable_i && calendar_select_i;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seconds_count_o <= 8'h00;
      minutes_count_o <= 8'h00;
      hours_count_o <= 8'h00;
      weekday_count_o <= 3'h0;
      month_day_count_o <= 8'h00;
      month_count_o <= 8'h00;
      year_low_count_o <= 8'h00;
      year_high_count_o <= 8'h00;
      first_prescaler_o <= 8'h00;
      second_prescaler_o <= 7'h00;
    end
    else
    begin
      seconds_count_o <= sec_reg;
      minutes_count_o <= min_reg;
      hours_count_o <= hour_reg;
      weekday_count_o <= dow_reg;
      month_day_count_o <= mday_reg;
      month_count_o <= mon_reg;
      year_low_count_o <= year_reg[7:0];
      year_high_count_o <= year_reg[15:8];
      first_prescaler_o <= ps0_reg;
      second_prescaler_o <= ps1_reg;
    end
  end
  assign alarm_flag_o = alarm_flag_reg;
  assign time_ready_o = ready_reg;
  assign time_ready_irq_flag_o = rflag_reg;
  assign time_ready_irq_o = rirq_reg;
endmodule : rtc_calendar_alarm_core
`default_nettype wire

/* File: testbench/rtc_calendar_alarm_core_properties.sv */
// Concurrent checks on the ports of the calendar and alarm core
`timescale 1ns/1ps
`default_nettype none
module rtc_core_checker (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic calendar_select_i,
  input wire logic main_count_hold_i,
  input wire logic wr_en_i,
  input wire logic alarm_flag_clear_i,
  input wire logic time_ready_irq_enable_i,
  input wire logic time_ready_flag_clear_i,
  input wire logic time_ready_serviced_i,
  input wire logic [7:0] seconds_count_o,
  input wire logic [7:0] first_prescaler_o,
  input wire logic [6:0] second_prescaler_o,
  input wire logic alarm_flag_o,
  input wire logic time_ready_o,
  input wire logic time_ready_irq_flag_o,
  input wire logic time_ready_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Ready, flag and alarm relations
  // ****************************************
  // Request is registered from the flag and the enable of the cycle before
  property p_irq;
    time_ready_irq_o == (time_ready_irq_flag_o && $past(time_ready_irq_enable_i));
  endproperty
  a_irq: assert property (p_irq) else $error("ready irq not flag and enable");
  property p_cnt_rdy;
    !calendar_select_i [*3] |-> !time_ready_o && !time_ready_irq_flag_o;
  endproperty
  a_cnt_rdy: assert property (p_cnt_rdy) else $error("ready active in counter mode");
  property p_cnt_alarm; !calendar_select_i [*3] |-> !alarm_flag_o; endproperty
  a_cnt_alarm: assert property (p_cnt_alarm) else $error("alarm in counter mode");
  property p_rdy_set;
    calendar_select_i && $rose(time_ready_o) |-> ##[0:2] time_ready_irq_flag_o;
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready rise did not set flag");
  property p_rdy_clr;
    (time_ready_flag_clear_i || time_ready_serviced_i) && time_ready_o && $past(time_ready_o)
      |=> !time_ready_irq_flag_o;
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready flag not cleared");
  property p_rdy_mid;
    calendar_select_i && $past(calendar_select_i) && second_prescaler_o == 7'h40
      |-> time_ready_o;
  endproperty
  a_rdy_mid: assert property (p_rdy_mid) else $error("ready low mid second");
  property p_rdy_win; second_prescaler_o == 7'h7f && first_prescaler_o == 8'hc0 |-> !time_ready_o; endproperty
  a_rdy_win: assert property (p_rdy_win) else $error("ready high in keepout");
  // ****************************************
  // Prescaler and count relations
  // ****************************************
  property p_hold; (main_count_hold_i && !wr_en_i) [*3] |-> $stable(first_prescaler_o); endproperty
  a_hold: assert property (p_hold) else $error("prescaler moved in hold");
  property p_carry; $changed(second_prescaler_o) |-> first_prescaler_o == 8'h00; endproperty
  a_carry: assert property (p_carry) else $error("second stage moved off carry");
  property p_sec;
    $changed(seconds_count_o) |-> first_prescaler_o == 8'h00 && second_prescaler_o == 7'h00;
  endproperty
  a_sec: assert property (p_sec) else $error("seconds moved off the one second tick");
  property p_af_clr;
    alarm_flag_clear_i && second_prescaler_o != 7'h7f |=> !alarm_flag_o;
  endproperty
  a_af_clr: assert property (p_af_clr) else $error("alarm flag not cleared");
endmodule : rtc_core_checker
bind rtc_calendar_alarm_core rtc_core_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .calendar_select_i(calendar_select_i), .main_count_hold_i(main_count_hold_i), .wr_en_i(wr_en_i),
  .alarm_flag_clear_i(alarm_flag_clear_i), .time_ready_irq_enable_i(time_ready_irq_enable_i),
  .time_ready_flag_clear_i(time_ready_flag_clear_i), .time_ready_serviced_i(time_ready_serviced_i),
  .seconds_count_o(seconds_count_o), .first_prescaler_o(first_prescaler_o),
  .second_prescaler_o(second_prescaler_o), .alarm_flag_o(alarm_flag_o), .time_ready_o(time_ready_o),
  .time_ready_irq_flag_o(time_ready_irq_flag_o), .time_ready_irq_o(time_ready_irq_o));
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the calendar and alarm core
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, aux = 1'b0, cal = 1'b1, bcd = 1'b1, hold = 1'b0, psh = 1'b0;
  logic we = 1'b0, afc = 1'b0, rie = 1'b1, rfc = 1'b0, rsv = 1'b0;
  logic [2:0] ws = 3'h0;
  logic [2:0] awd = 3'h5;
  logic [3:0] aen = 4'hb;
  logic [11:0] wdat = 12'h000;
  logic [7:0] sec, mn, hr, md, mon, yl, yh, ps0, rec;
  logic [6:0] ps1;
  logic [2:0] wd;
  logic af, rdy, rf, ri;
  int n_fail = 0, n_checks = 0, i;
  rtc_calendar_alarm_core dut (.core_clk_i(clk), .rst_i(rst), .aux_clk_i(aux),
    .calendar_select_i(cal), .bcd_format_select_i(bcd), .main_count_hold_i(hold),
    .first_prescaler_hold_i(psh), .second_prescaler_hold_i(psh), .wr_en_i(we), .wr_sel_i(ws),
    .wr_data_i(wdat), .alarm_minute_i(8'h00), .alarm_hour_i(8'h00), .alarm_weekday_i(awd),
    .alarm_month_day_i(8'h29), .alarm_field_enable_i(aen), .alarm_flag_clear_i(afc),
    .time_ready_irq_enable_i(rie), .time_ready_flag_clear_i(rfc), .time_ready_serviced_i(rsv),
    .seconds_count_o(sec), .minutes_count_o(mn), .hours_count_o(hr), .weekday_count_o(wd),
    .month_day_count_o(md), .month_count_o(mon), .year_low_count_o(yl), .year_high_count_o(yh),
    .first_prescaler_o(ps0), .second_prescaler_o(ps1), .alarm_flag_o(af), .time_ready_o(rdy),
    .time_ready_irq_flag_o(rf), .time_ready_irq_o(ri));
  // Clock of 10 ns period
  always #5 clk = ~clk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One aux rise per four core cycles, slow enough for the input synchroniser
  task automatic aux_run(input int n);
    repeat (n)
    begin
      aux = 1'b1;
      cyc(2);
      aux = 1'b0;
      cyc(2);
    end
  endtask : aux_run
  task automatic wr(input logic [2:0] sel, input logic [11:0] d);
    we = 1'b1;
    ws = sel;
    wdat = d;
    cyc(1);
    we = 1'b0;
    cyc(2);
  endtask : wr
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_format;
    chk("mday", md, 12'h001);
    wr(3'd0, 12'h030);
    chk("sec", sec, 12'h030);
    bcd = 1'b0;
    cyc(3);
    chk("sec", sec, 12'h000);
    chk("month", mon, 12'h001);
    bcd = 1'b1;
    cyc(3);
    $display("format test done");
  endtask : t_format
  task automatic t_counter;
    wr(3'd4, 12'h015);
    chk("mday written", md, 12'h015);
    // Move the prescaler off zero so the re-entry clear is visible
    aux_run(5);
    cal = 1'b0;
    cyc(3);
    wr(3'd1, 12'h005);
    chk("min", mn, 12'h000);
    chk("ready", rdy, 12'h000);
    cal = 1'b1;
    cyc(3);
    chk("mday", md, 12'h001);
    chk("ps0", ps0, 12'h000);
    $display("counter test done");
  endtask : t_counter
  task automatic t_hold;
    aux_run(10);
    hold = 1'b1;
    cyc(3);
    rec = ps0;
    aux_run(20);
    chk("ps0 held", ps0, {4'h0, rec});
    hold = 1'b0;
    psh = 1'b1;
    aux_run(10);
    cyc(2);
    chk("ps0 run", ps0, {4'h0, rec + 8'd10});
    psh = 1'b0;
    $display("hold test done");
  endtask : t_hold
  task automatic t_tick;
    // Alarm disarmed and its flag cleared before the time is loaded
    aen = 4'h0;
    afc = 1'b1;
    cyc(1);
    afc = 1'b0;
    wr(3'd0, 12'h059);
    wr(3'd1, 12'h059);
    wr(3'd2, 12'h023);
    wr(3'd3, 12'h006);
    wr(3'd4, 12'h028);
    wr(3'd5, 12'h002);
    wr(3'd6, 12'h024);
    wr(3'd7, 12'h200);
    // Weekday compare disagrees but its enable is off
    awd = 3'h5;
    aen = 4'hb;
    // One aux rise short of a full second
    for (i = 0; i < 32767; i++)
    begin
      aux_run(1);
      if (i == 16384)
      begin
        chk("ready mid", rdy, 12'h001);
        chk("ready flag set", rf, 12'h001);
        rfc = 1'b1;
        cyc(1);
        rfc = 1'b0;
        cyc(1);
        chk("ready flag", rf, 12'h000);
      end
    end
    chk("keepout", rdy, 12'h000);
    chk("sec early", sec, 12'h059);
    chk("alarm early", af, 12'h000);
    aux_run(1);
    cyc(1);
    chk("sec tick", sec, 12'h000);
    chk("alarm", af, 12'h001);
    aux_run(100);
    cyc(3);
    chk("ready read", rdy, 12'h001);
    chk("min", mn, 12'h000);
    chk("hour", hr, 12'h000);
    chk("weekday", wd, 12'h000);
    chk("mday", md, 12'h029);
    chk("month", mon, 12'h002);
    chk("year", {yh[3:0], yl}, 12'h024);
    chk("year high", yh, 12'h020);
    chk("ready irq", ri, 12'h001);
    rsv = 1'b1;
    afc = 1'b1;
    cyc(1);
    rsv = 1'b0;
    afc = 1'b0;
    cyc(2);
    chk("ready flag", rf, 12'h000);
    chk("alarm", af, 12'h000);
    $display("tick test done");
  endtask : t_tick
  // Main sequence
  initial
  begin
    cyc(5);
    rst = 1'b0;
    cyc(3);
    t_format();
    t_counter();
    t_hold();
    t_tick();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
